// file: core/motion_input.v
// Purpose: Command-input logic of an integrated stepper drive
// Assumes: Pins are asynchronous; registers over Avalon-MM with waitrequest
// Notes: Current outputs are percent codes for the power stage
//
// Summary of operation
// - Pulse-and-direction: one pulse one step, direction from rotation sense input.
// - Speed follows the rate of filtered motion pulses.
// - Clockwise/counterclockwise format: separate pulse input for each direction.
// - Quadrature A/B follow: encoder transitions become steps and direction.
// - Resolution any multiple of 2, finest 51200 per turn.
// - Step smoothing setting up to 2500; unneeded at 2000 or more.
// - Smoothing delays executed steps slightly behind commands.
// - Digital noise filter on pulse and sense inputs, default 7.5 MHz.
// - Running current is a percentage of rated current, 100 is maximum.
// - Accel/decel current applies while speed changes.
// - After idle delay, current drops to idle setting.
// - Idle current relative to running current, default 50 percent.
// - Two command modes: pulse inputs or streaming over Ethernet.
// - Streaming: pulse input is CW limit, sense input is CCW limit.
// - Streaming: permit input becomes home switch.
// - Permit active disables motor power, inactive enables it.
// - Permit function: not used, enable, or clear latched faults.
// - Output: fault, automatic brake, or tachometer per revolution.
`timescale 1ns/100ps
`default_nettype none
`include "motion_input_map.vh"
module motion_input #(
   parameter FILT_BITS = 8,
   parameter IDLE_BITS = 32
) (
   input wire clk,
   input wire reset,
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   input wire clockwise_pulse_in,
   input wire counterclockwise_pulse_in,
   input wire permit_in,
   input wire fault_in,
   output reg step_q,
   output reg step_dir_q,
   output reg motor_enable_q,
   output reg [7:0] current_pct_q,
   output reg cw_limit_q,
   output reg ccw_limit_q,
   output reg home_q,
   output reg fault_clear_q,
   output reg prog_out_q
);
   reg [31:0] ctrl_q;
   reg [31:0] res_q;
   reg [31:0] smooth_q;
   reg [31:0] filt_q;
   reg [31:0] cur_q;
   reg [31:0] idle_dly_q;
   reg [31:0] pos_q;
   reg ack_q;

   // Pin synchronisers, first stage read only by second
   reg [2:0] sync1_q;
   reg [2:0] sync2_q;
   // One driver per bit, from each filter lane
   wire [2:0] filt_q_lvl;
   wire [2:0] raw = {permit_in, counterclockwise_pulse_in, clockwise_pulse_in};
   always @(posedge clk) begin
      if (reset) begin
         sync1_q <= 3'h0;
         sync2_q <= 3'h0;
      end else begin
         sync1_q <= raw;
         sync2_q <= sync1_q;
      end
   end
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_filt
         reg [FILT_BITS-1:0] cnt_q;
         reg lvl_q;
         assign filt_q_lvl[gi] = lvl_q;
         always @(posedge clk) begin
            if (reset) begin
               cnt_q <= {FILT_BITS{1'b0}};
               lvl_q <= 1'b0;
            end else if (sync2_q[gi] == lvl_q) begin
               cnt_q <= {FILT_BITS{1'b0}};
            end else if (cnt_q >= filt_q[FILT_BITS-1:0]) begin
               cnt_q <= {FILT_BITS{1'b0}};
               lvl_q <= sync2_q[gi];
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   endgenerate
   wire streaming = ctrl_q[`CTRL_MODE_LSB];
   wire [1:0] fmt = ctrl_q[`CTRL_FMT_LSB +: 2];
   wire [1:0] en_fn = ctrl_q[`CTRL_EN_FN_LSB +: 2];
   wire [1:0] out_fn = ctrl_q[`CTRL_OUT_FN_LSB +: 2];
   reg [2:0] prev_q;
   always @(posedge clk) begin
      if (reset) begin
         prev_q <= 3'h0;
      end else begin
         prev_q <= filt_q_lvl;
      end
   end
   wire a_rise = filt_q_lvl[0] & ~prev_q[0];
   wire b_rise = filt_q_lvl[1] & ~prev_q[1];
   wire a_chg = filt_q_lvl[0] ^ prev_q[0];
   wire b_chg = filt_q_lvl[1] ^ prev_q[1];
   // Step decode per format
   reg cmd_step, cmd_dir;
   always @* begin
      cmd_step = 1'b0;
      cmd_dir = 1'b0;
      if (!streaming) begin
         case (fmt)
            // pulse counts, sense taken at that edge
            `FMT_PULSE_DIR: begin
               cmd_step = a_rise;
               cmd_dir = filt_q_lvl[1];
            end
            `FMT_CW_CCW: begin
               cmd_step = a_rise ^ b_rise;
               cmd_dir = b_rise;
            end
            `FMT_QUAD: begin
               cmd_step = a_chg ^ b_chg;
               cmd_dir = a_chg ? (filt_q_lvl[0] == filt_q_lvl[1]) :
                  (filt_q_lvl[0] != filt_q_lvl[1]);
            end
            default: begin
               cmd_step = 1'b0;
               cmd_dir = 1'b0;
            end
         endcase
      end
   end
   // smoothing holds each step back by the smoothing setting, causing lag
   // Limitation: a step arriving while one is pending replaces it and restarts the delay
   reg [11:0] smooth_cnt_q;
   reg pend_q, pend_dir_q;
   wire [11:0] smooth_set = (smooth_q[11:0] > `SMOOTH_MAX) ? `SMOOTH_MAX : smooth_q[11:0];
   wire smoothing = (smooth_set != 12'h000) && (res_q < `SMOOTH_RES_MIN);
   wire issue = smoothing ? (pend_q && smooth_cnt_q == 12'h000) : cmd_step;
   wire issue_dir = smoothing ? pend_dir_q : cmd_dir;
   always @(posedge clk) begin
      if (reset) begin
         smooth_cnt_q <= 12'h000;
         pend_q <= 1'b0;
         pend_dir_q <= 1'b0;
      end else if (!smoothing) begin
         // Stale held step must not replay when smoothing returns
         pend_q <= 1'b0;
         smooth_cnt_q <= 12'h000;
      end else if (cmd_step) begin
         // delay bounded by the clamped setting
         pend_q <= 1'b1;
         pend_dir_q <= cmd_dir;
         smooth_cnt_q <= smooth_set;
      end else if (pend_q && smooth_cnt_q != 12'h000) begin
         smooth_cnt_q <= smooth_cnt_q - 12'h001;
      end else if (issue) begin
         pend_q <= 1'b0;
      end
   end
   // Step output, position and per-revolution count
   reg [31:0] rev_cnt_q;
   reg tach_q;
   always @(posedge clk) begin
      if (reset) begin
         step_q <= 1'b0;
         step_dir_q <= 1'b0;
         pos_q <= 32'h0000_0000;
         rev_cnt_q <= 32'h0000_0000;
         tach_q <= 1'b0;
      end else begin
         step_q <= issue & motor_enable_q;
         tach_q <= 1'b0;
         if (issue & motor_enable_q) begin
            step_dir_q <= issue_dir;
            pos_q <= issue_dir ? pos_q - 32'h0000_0001 : pos_q + 32'h0000_0001;
            if (rev_cnt_q + 32'h0000_0001 >= res_q) begin
               rev_cnt_q <= 32'h0000_0000;
               tach_q <= 1'b1;
            end else begin
               rev_cnt_q <= rev_cnt_q + 32'h0000_0001;
            end
         end
      end
   end
   // speed tracked as period between pulses; change flags accel
   reg [23:0] period_cnt_q, last_period_q;
   reg accel_q;
   always @(posedge clk) begin
      if (reset) begin
         period_cnt_q <= 24'h00_0000;
         last_period_q <= 24'h00_0000;
         accel_q <= 1'b0;
      end else if (issue) begin
         period_cnt_q <= 24'h00_0000;
         last_period_q <= period_cnt_q;
         // a rate change of more than 1/8 counts as accel/decel
         accel_q <= (period_cnt_q > last_period_q + (last_period_q >> 3)) ||
            (period_cnt_q + (period_cnt_q >> 3) < last_period_q);
      end else if (period_cnt_q != 24'hFF_FFFF) begin
         period_cnt_q <= period_cnt_q + 24'h00_0001;
      end
   end
   // idle timer restarts on every issued step
   reg [IDLE_BITS-1:0] idle_cnt_q;
   reg idle_q;
   always @(posedge clk) begin
      if (reset) begin
         idle_cnt_q <= {IDLE_BITS{1'b0}};
         idle_q <= 1'b0;
      end else if (issue) begin
         idle_cnt_q <= {IDLE_BITS{1'b0}};
         idle_q <= 1'b0;
      end else if (idle_cnt_q >= idle_dly_q[IDLE_BITS-1:0]) begin
         idle_q <= 1'b1;
      end else begin
         idle_cnt_q <= idle_cnt_q + 1'b1;
      end
   end
   // percent of rated; idle relative to running
   wire [7:0] run_pct = cur_q[`CUR_RUN_LSB +: 8];
   wire [7:0] acc_pct = cur_q[`CUR_ACC_LSB +: 8];
   wire [7:0] idle_rel = cur_q[`CUR_IDLE_LSB +: 8];
   wire [15:0] idle_prod = {8'h00, run_pct} * {8'h00, idle_rel};
   wire [15:0] idle_quot = idle_prod / `PCT_FULL;
   wire [7:0] idle_pct = idle_quot[7:0];

   reg fault_latch_q;
   wire permit = filt_q_lvl[2];
   always @(posedge clk) begin
      if (reset) begin
         motor_enable_q <= 1'b0;
         current_pct_q <= 8'h00;
         cw_limit_q <= 1'b0;
         ccw_limit_q <= 1'b0;
         home_q <= 1'b0;
         fault_clear_q <= 1'b0;
         fault_latch_q <= 1'b0;
         prog_out_q <= 1'b0;
      end else begin
         cw_limit_q <= streaming & filt_q_lvl[0];
         ccw_limit_q <= streaming & filt_q_lvl[1];
         home_q <= streaming & permit;
         fault_clear_q <= !streaming && en_fn == `EN_FN_CLEAR && permit;
         // Set wins over clear
         if (fault_in) begin
            fault_latch_q <= 1'b1;
         end else if (!streaming && en_fn == `EN_FN_CLEAR && permit) begin
            fault_latch_q <= 1'b0;
         end
         motor_enable_q <= !fault_latch_q &&
            !(!streaming && en_fn == `EN_FN_ENABLE && permit);
         if (!motor_enable_q) begin
            current_pct_q <= 8'h00;
         end else if (idle_q) begin
            current_pct_q <= idle_pct;
         end else if (accel_q) begin
            current_pct_q <= acc_pct;
         end else begin
            current_pct_q <= run_pct;
         end
         case (out_fn)
            `OUT_FN_FAULT: prog_out_q <= fault_latch_q;
            `OUT_FN_BRAKE: prog_out_q <= motor_enable_q;
            `OUT_FN_TACH: prog_out_q <= tach_q;
            default: prog_out_q <= 1'b0;
         endcase
      end
   end
   // Avalon slave: one wait cycle per access
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   wire [31:0] wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   // Write commits at the edge that ends the wait
   wire wr = avs_write & ack_q;
   wire [31:0] smooth_wr = (smooth_q & ~wmask) | (avs_writedata & wmask);

   always @(posedge clk) begin
      if (reset) begin
         ack_q <= 1'b0;
         avs_readdata <= 32'h0000_0000;
         ctrl_q <= `CTRL_RESET;
         res_q <= `RES_RESET;
         smooth_q <= `SMOOTH_RESET;
         filt_q <= `FILT_DEFAULT_CYC;
         cur_q <= `CURRENT_RESET;
         idle_dly_q <= `IDLE_DLY_RESET;
      end else begin
         ack_q <= (avs_read | avs_write) & ~ack_q;
         if (wr) begin
            case (avs_address)
               `REG_CTRL: ctrl_q <= (ctrl_q & ~wmask) | (avs_writedata & wmask);
               // odd resolution rounded down to even
               `REG_RES: res_q <= ((res_q & ~wmask) | (avs_writedata & wmask)) &
                  32'hFFFF_FFFE;
               // setting never held above its maximum
               `REG_SMOOTH: smooth_q <= (smooth_wr > {20'h0_0000, `SMOOTH_MAX}) ?
                  {20'h0_0000, `SMOOTH_MAX} : smooth_wr;
               `REG_FILT: filt_q <= (filt_q & ~wmask) | (avs_writedata & wmask);
               `REG_CURRENT: cur_q <= (cur_q & ~wmask) | (avs_writedata & wmask);
               `REG_IDLE_DLY: idle_dly_q <= (idle_dly_q & ~wmask) | (avs_writedata & wmask);
               default: ;
            endcase
         end
         if (avs_read & ~ack_q) begin
            case (avs_address)
               `REG_CTRL: avs_readdata <= ctrl_q;
               `REG_RES: avs_readdata <= res_q;
               `REG_SMOOTH: avs_readdata <= smooth_q;
               `REG_FILT: avs_readdata <= filt_q;
               `REG_CURRENT: avs_readdata <= cur_q;
               `REG_IDLE_DLY: avs_readdata <= idle_dly_q;
               `REG_STATUS: avs_readdata <= {20'h0_0000, current_pct_q, idle_q,
                  fault_latch_q, motor_enable_q, step_dir_q};
               `REG_POSITION: avs_readdata <= pos_q;
               default: avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// file: core/motion_input_map.vh
// Purpose: Constants for the pulse/direction command input block
// Assumes: 50 MHz system clock
// Notes: Register offsets are byte addresses of 32-bit words
`ifndef MOTION_INPUT_MAP_VH
`define MOTION_INPUT_MAP_VH
`define CLK_HZ 50000000
`define FILT_DEFAULT_HZ 7500000
`define FILT_DEFAULT_CYC (((`CLK_HZ / `FILT_DEFAULT_HZ) < 1) ? 1 : (`CLK_HZ / `FILT_DEFAULT_HZ))
`define REG_CTRL 8'h00
`define REG_RES 8'h04
`define REG_SMOOTH 8'h08
`define REG_FILT 8'h0C
`define REG_CURRENT 8'h10
`define REG_IDLE_DLY 8'h14
`define REG_STATUS 8'h18
`define REG_POSITION 8'h1C
`define CTRL_MODE_LSB 0
`define CTRL_FMT_LSB 1
`define CTRL_EN_FN_LSB 3
`define CTRL_OUT_FN_LSB 5
`define CTRL_RESET 32'h0000_0000
`define RES_RESET 32'h0000_C800
`define SMOOTH_RESET 32'h0000_0000
`define SMOOTH_MAX 12'h9C4
`define SMOOTH_RES_MIN 32'h0000_07D0
`define PCT_FULL 16'h0064
`define CUR_RUN_LSB 0
`define CUR_ACC_LSB 8
`define CUR_IDLE_LSB 16
`define CURRENT_RESET 32'h0032_6464
`define IDLE_DLY_RESET 32'h0007_A120
`define FMT_PULSE_DIR 2'h0
`define FMT_CW_CCW 2'h1
`define FMT_QUAD 2'h2
`define EN_FN_NONE 2'h0
`define EN_FN_ENABLE 2'h1
`define EN_FN_CLEAR 2'h2
`define OUT_FN_NONE 2'h0
`define OUT_FN_FAULT 2'h1
`define OUT_FN_BRAKE 2'h2
`define OUT_FN_TACH 2'h3
`endif

// file: dv/step_source.sv
// Purpose: Indexer model driving step commands into the drive
// Assumes: go is high for one cycle; fmt, rev and n stay steady
// Notes: Steady rate only, so no ramp profile is modelled
`timescale 1ns/100ps
`default_nettype none
module step_source #(
   parameter int HALF = 12
) (
   input wire logic clk,
   input wire logic go,
   input wire logic [1:0] fmt,
   input wire logic rev,
   input wire logic [7:0] n,
   output logic a_pin,
   output logic b_pin,
   output logic busy
);
   initial begin
      a_pin = 1'b0;
      b_pin = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge clk);
         if (go) begin
            busy <= 1'b1;
            if (fmt == 2'h0) b_pin <= rev;
            repeat (HALF) @(posedge clk);
            repeat (n) begin
               if (fmt == 2'h2) begin
                  for (int k = 0; k < 4; k++) begin
                     if (rev ^ k[0]) b_pin <= !b_pin;
                     else a_pin <= !a_pin;
                     repeat (HALF) @(posedge clk);
                  end
               end else begin
                  if (fmt == 2'h1 && rev) b_pin <= 1'b1;
                  else a_pin <= 1'b1;
                  repeat (HALF) @(posedge clk);
                  a_pin <= 1'b0;
                  if (fmt == 2'h1) b_pin <= 1'b0;
                  repeat (HALF) @(posedge clk);
               end
            end
            busy <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// file: dv/motion_input_props.sv
// Purpose: Temporal checks on the motion input block
// Assumes: One clock, synchronous active-high reset
// Notes: Control copy rebuilt from accepted bus writes
`timescale 1ns/100ps
`default_nettype none
module motion_input_props (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] avs_address,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic avs_waitrequest,
   input wire logic clockwise_pulse_in,
   input wire logic permit_in,
   input wire logic fault_in,
   input wire logic step_q,
   input wire logic motor_enable_q,
   input wire logic [7:0] current_pct_q,
   input wire logic cw_limit_q,
   input wire logic ccw_limit_q,
   input wire logic home_q,
   input wire logic prog_out_q
);
   logic [7:0] ctl_q;
   wire logic str = ctl_q[0];
   always_ff @(posedge clk) begin
      if (reset) ctl_q <= 8'h00;
      else if (avs_write && !avs_waitrequest && avs_address == 8'h00 && avs_byteenable[0])
         ctl_q <= avs_writedata[7:0];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_cw_held;
      (str && clockwise_pulse_in) [*8];
   endsequence
   sequence s_home_held;
      (str && permit_in) [*8];
   endsequence
   sequence s_permit_held;
      (!str && ctl_q[4:3] == 2'h1 && permit_in) [*8];
   endsequence
   property p_step_pulse;
      step_q |=> !step_q;
   endproperty
   a_step_pulse: assert property (p_step_pulse) else $error("step too long");
   property p_step_enabled;
      step_q |-> motor_enable_q;
   endproperty
   a_step_enabled: assert property (p_step_enabled) else $error("step while off");
   property p_permit_off;
      s_permit_held |-> ##[0:12] !motor_enable_q;
   endproperty
   a_permit_off: assert property (p_permit_off) else $error("permit ignored");
   property p_cw_limit;
      s_cw_held |-> ##[0:12] cw_limit_q;
   endproperty
   a_cw_limit: assert property (p_cw_limit) else $error("limit missed");
   property p_home;
      s_home_held |-> ##[0:12] home_q;
   endproperty
   a_home: assert property (p_home) else $error("home missed");
   property p_no_limits;
      (!str) [*4] |-> !(cw_limit_q || ccw_limit_q || home_q);
   endproperty
   a_no_limits: assert property (p_no_limits) else $error("limit outside streaming");
   property p_zero_current;
      (!motor_enable_q) [*2] |-> current_pct_q == 8'h00;
   endproperty
   a_zero_current: assert property (p_zero_current) else $error("current while off");
   property p_fault_out;
      ctl_q[6:5] == 2'h1 && fault_in |-> ##[1:3] prog_out_q;
   endproperty
   a_fault_out: assert property (p_fault_out) else $error("fault not shown");
endmodule
bind motion_input motion_input_props motion_input_props_inst (.clk(clk), .reset(reset),
   .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
   .clockwise_pulse_in(clockwise_pulse_in), .permit_in(permit_in), .fault_in(fault_in),
   .step_q(step_q), .motor_enable_q(motor_enable_q), .current_pct_q(current_pct_q),
   .cw_limit_q(cw_limit_q), .ccw_limit_q(ccw_limit_q), .home_q(home_q),
   .prog_out_q(prog_out_q));
`default_nettype wire

// file: dv/motion_input_tb.sv
// Purpose: Self-checking bench for the motion input block
// Assumes: Filter at reset value; smoothing set per scenario
// Notes: Idle delay shortened through its register
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module motion_input_tb;
   logic clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
   logic [7:0] avs_address = 8'h00, n = 8'h00;
   logic [31:0] avs_writedata = 32'h0000_0000, rd;
   logic [3:0] avs_byteenable = 4'hf;
   logic permit_in = 1'b0, fault_in = 1'b0, cw_tb = 1'b0, ccw_tb = 1'b0, go = 1'b0, rev = 1'b0;
   logic [1:0] fmt = 2'h0;
   wire logic [31:0] avs_readdata;
   wire logic [7:0] current_pct_q;
   wire logic avs_waitrequest, a_pin, b_pin, busy, step_q, step_dir_q, motor_enable_q;
   wire logic cw_limit_q, ccw_limit_q, home_q, fault_clear_q, prog_out_q;
   int failures = 0, tests_run = 0, cyc = 0, tach_n = 0, t0 = 0;
   step_source step_source_inst (.clk(clk), .go(go), .fmt(fmt), .rev(rev), .n(n),
      .a_pin(a_pin), .b_pin(b_pin), .busy(busy));
   motion_input motion_input_inst (.clk(clk), .reset(reset), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .clockwise_pulse_in(a_pin | cw_tb),
      .counterclockwise_pulse_in(b_pin | ccw_tb), .permit_in(permit_in), .fault_in(fault_in),
      .step_q(step_q), .step_dir_q(step_dir_q), .motor_enable_q(motor_enable_q),
      .current_pct_q(current_pct_q), .cw_limit_q(cw_limit_q), .ccw_limit_q(ccw_limit_q),
      .home_q(home_q), .fault_clear_q(fault_clear_q), .prog_out_q(prog_out_q));
   initial forever #10 clk = ~clk;
   task automatic give_verdict;
      $display("Checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         failures++;
         give_verdict;
      end
   end
   // Tachometer pulses seen on the output
   always @(posedge clk) begin
      if (prog_out_q === 1'b1) tach_n <= tach_n + 1;
   end
   // Request held until waitrequest sampled low at a rising edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      `CHK(nm, e, rd)
   endtask
   // Pin latency is far below the 20-cycle settle
   task automatic run(input logic [1:0] f, input logic r, input logic [7:0] c);
      @(posedge clk);
      fmt <= f;
      rev <= r;
      n <= c;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(negedge clk);
      while (busy !== 1'b0) @(negedge clk);
      repeat (20) @(posedge clk);
   endtask
   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      rchk("res", 8'h04, 32'h0000_C800);
      rchk("filt", 8'h0C, 32'h0000_0006);
      rchk("current", 8'h10, 32'h0032_6464);
      rchk("idle_dly", 8'h14, 32'h0007_A120);
      rchk("unmapped", 8'h40, 32'h0000_0000);
      bus(1'b1, 8'h04, 32'h0000_0065);
      rchk("res_even", 8'h04, 32'h0000_0064);
      bus(1'b1, 8'h08, 32'h0000_0FFF);
      rchk("smooth_max", 8'h08, 32'h0000_09C4);
      bus(1'b1, 8'h04, 32'h0000_C800);
      `CHK("enable", 1'b1, motor_enable_q)
      run(2'h0, 1'b1, 8'h03);
      `CHK("dir_ccw", 1'b1, step_dir_q)
      run(2'h0, 1'b0, 8'h05);
      rchk("pos_pd", 8'h1C, 32'h0000_0002);
      bus(1'b1, 8'h1C, 32'h0000_0000);
      rchk("pos_ro", 8'h1C, 32'h0000_0002);
      bus(1'b1, 8'h00, 32'h0000_0002);
      run(2'h1, 1'b0, 8'h04);
      run(2'h1, 1'b1, 8'h02);
      rchk("pos_cw", 8'h1C, 32'h0000_0004);
      bus(1'b1, 8'h00, 32'h0000_0004);
      run(2'h2, 1'b0, 8'h02);
      rchk("pos_quad_fwd", 8'h1C, 32'h0000_000C);
      run(2'h2, 1'b1, 8'h02);
      rchk("pos_quad", 8'h1C, 32'h0000_0004);
      bus(1'b1, 8'h10, 32'h0032_6450);
      bus(1'b1, 8'h14, 32'h0000_0064);
      repeat (300) @(posedge clk);
      `CHK("idle_cur", 8'h28, current_pct_q)
      run(2'h2, 1'b0, 8'h01);
      `CHK("run_cur", 8'h50, current_pct_q)
      bus(1'b1, 8'h00, 32'h0000_0008);
      permit_in <= 1'b1;
      repeat (20) @(posedge clk);
      `CHK("permit_off", 1'b0, motor_enable_q)
      `CHK("cur_off", 8'h00, current_pct_q)
      permit_in <= 1'b0;
      repeat (20) @(posedge clk);
      `CHK("permit_on", 1'b1, motor_enable_q)
      bus(1'b1, 8'h00, 32'h0000_0030);
      fault_in <= 1'b1;
      @(posedge clk);
      fault_in <= 1'b0;
      repeat (5) @(posedge clk);
      `CHK("fault_out", 1'b1, prog_out_q)
      permit_in <= 1'b1;
      repeat (20) @(posedge clk);
      `CHK("clear_pin", 1'b1, fault_clear_q)
      permit_in <= 1'b0;
      repeat (20) @(posedge clk);
      `CHK("fault_gone", 1'b0, prog_out_q)
      bus(1'b1, 8'h00, 32'h0000_0040);
      repeat (5) @(posedge clk);
      `CHK("brake", 1'b1, prog_out_q)
      bus(1'b1, 8'h04, 32'h0000_0004);
      bus(1'b1, 8'h08, 32'h0000_0040);
      bus(1'b1, 8'h00, 32'h0000_0060);
      run(2'h0, 1'b0, 8'h01);
      rchk("lag_held", 8'h1C, 32'h0000_0008);
      repeat (60) @(posedge clk);
      rchk("lag_done", 8'h1C, 32'h0000_0009);
      bus(1'b1, 8'h08, 32'h0000_0000);
      t0 = tach_n;
      run(2'h0, 1'b0, 8'h08);
      `CHK("tach", 2, tach_n - t0)
      bus(1'b1, 8'h00, 32'h0000_0001);
      cw_tb <= 1'b1;
      permit_in <= 1'b1;
      repeat (20) @(posedge clk);
      `CHK("cw_lim", 1'b1, cw_limit_q)
      `CHK("home", 1'b1, home_q)
      cw_tb <= 1'b0;
      ccw_tb <= 1'b1;
      permit_in <= 1'b0;
      repeat (20) @(posedge clk);
      `CHK("ccw_lim", 1'b1, ccw_limit_q)
      `CHK("home_off", 1'b0, home_q)
      give_verdict;
   end
endmodule
`default_nettype wire
